// ### verilog/psa_pkg.sv
// constants and types for the packed simd alu slice
// assumes a single core clock and a decoder on that clock
//
// Summary of operation
// - upper load writes immediate to bits 31:16
// - upper load leaves all flags unchanged
// - word swap reverses all four bytes
// - halfword swap exchanges bytes per halfword
// - low half swapped then sign extended
// - mirror reverses all 32 bits
// - swaps, mirror, select, halving adds: flags kept
// - dual halfword add, sums truncated to 16
// - dual add sets flag pairs from sum signs
// - quad byte add, sums truncated to 8
// - quad add sets flag k from lane sign
// - add-sub exchange: low diff, high sum
// - add-sub exchange flag pairs from signs
// - sub-add exchange: low sum, high diff
// - sub-add exchange flag pairs from signs
// - select takes byte k by flag k
// - dual halving add halves each halfword sum
// - quad halving add halves each byte sum
package psa_pkg;

  // ===========================================
  // widths
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam int LANE_N = 4;

  // ===========================================
  // reset values
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic [3:0]  GE_RST     = 4'h0;

  // ===========================================
  // operation codes
  typedef enum logic [3:0] {
    OP_LOAD_UPPER = 4'h0,
    OP_SWAP_WORD  = 4'h1,
    OP_SWAP_HALF  = 4'h2,
    OP_SWAP_SEXT  = 4'h3,
    OP_MIRROR     = 4'h4,
    OP_DUAL_ADD   = 4'h5,
    OP_QUAD_ADD   = 4'h6,
    OP_ADD_SUB_X  = 4'h7,
    OP_SUB_ADD_X  = 4'h8,
    OP_SELECT     = 4'h9,
    OP_DUAL_HADD  = 4'hA,
    OP_QUAD_HADD  = 4'hB
  } psa_op_t;

  // ===========================================
  // whole module state
  typedef struct packed {
    logic [31:0] res;
    logic        res_we;
    logic [3:0]  ge;
    logic        ge_we;
  } psa_state_t;

endpackage : psa_pkg

// ### verilog/psa_alu.sv
// single cycle packed simd alu slice with lane flags
// assumes decoder and register file on core_clk drive inputs
`timescale 1ns/10ps
`default_nettype none

module psa_alu
  import psa_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // operation request
  input  wire logic        op_valid,
  input  wire logic [3:0]  op_code,
  input  wire logic        cond_pass,
  // operands
  input  wire logic [31:0] first_source,
  input  wire logic [31:0] second_source,
  input  wire logic [31:0] dest_old,
  input  wire logic [15:0] upper_immediate,
  // results
  output logic      [31:0] result,
  output logic             result_we,
  output logic      [3:0]  lane_ge_flags,
  output logic             lane_ge_we
);

  // ===========================================
  // lane arithmetic helpers

  // sign extended halfword add, one guard bit
  function automatic logic [16:0] add17(
    input logic [15:0] x,
    input logic [15:0] y
  );
    add17 = {x[15], x} + {y[15], y};
  endfunction : add17

  // sign extended halfword subtract
  function automatic logic [16:0] sub17(
    input logic [15:0] x,
    input logic [15:0] y
  );
    sub17 = {x[15], x} - {y[15], y};
  endfunction : sub17

  // sign extended byte add
  function automatic logic [8:0] add9(
    input logic [7:0] x,
    input logic [7:0] y
  );
    add9 = {x[7], x} + {y[7], y};
  endfunction : add9

  // ===========================================
  // state
  psa_state_t st_q;
  psa_state_t st_d;

  logic [31:0] a;
  logic [31:0] b;
  logic        go;
  logic [16:0] h_lo;
  logic [16:0] h_hi;
  logic [16:0] x_lo;
  logic [16:0] x_hi;
  logic [8:0]  bs [LANE_N];

  assign a  = first_source;
  assign b  = second_source;
  // a failed condition drops the whole operation
  assign go = op_valid && cond_pass;

  // ===========================================
  // lane sums, shared by plain and halving adds
  assign h_lo = add17(a[15:0], b[15:0]);
  assign h_hi = add17(a[31:16], b[31:16]);

  // exchange lanes; direction follows the code
  always_comb begin
    if (op_code == OP_ADD_SUB_X) begin
      x_lo = sub17(a[15:0], b[31:16]);
      x_hi = add17(a[31:16], b[15:0]);
    end else begin
      x_lo = add17(a[15:0], b[31:16]);
      x_hi = sub17(a[31:16], b[15:0]);
    end
  end

  genvar gk;
  generate
    for (gk = 0; gk < LANE_N; gk++) begin : g_byte
      assign bs[gk] = add9(a[8*gk +: 8], b[8*gk +: 8]);
    end
  endgenerate

  // ===========================================
  // next state
  always_comb begin
    st_d        = st_q;
    st_d.res_we = 1'b0;
    st_d.ge_we  = 1'b0;
    if (go) begin
      st_d.res_we = 1'b1;
      case (op_code)
        OP_LOAD_UPPER: begin
          // low half is carried through, flags kept
          st_d.res = {upper_immediate, dest_old[15:0]};
        end
        OP_SWAP_WORD: begin
          st_d.res = {a[7:0], a[15:8], a[23:16], a[31:24]};
        end
        OP_SWAP_HALF: begin
          st_d.res = {a[23:16], a[31:24], a[7:0], a[15:8]};
        end
        OP_SWAP_SEXT: begin
          st_d.res = {{16{a[7]}}, a[7:0], a[15:8]};
        end
        OP_MIRROR: begin
          for (int i = 0; i < DATA_W; i++) begin
            st_d.res[i] = a[DATA_W-1-i];
          end
        end
        OP_DUAL_ADD: begin
          // top bit of the 17 bit sum is the true sign
          st_d.res   = {h_hi[15:0], h_lo[15:0]};
          st_d.ge    = {{2{~h_hi[16]}}, {2{~h_lo[16]}}};
          st_d.ge_we = 1'b1;
        end
        OP_QUAD_ADD: begin
          for (int k = 0; k < LANE_N; k++) begin
            st_d.res[8*k +: 8] = bs[k][7:0];
            st_d.ge[k]         = ~bs[k][8];
          end
          st_d.ge_we = 1'b1;
        end
        OP_ADD_SUB_X,
        OP_SUB_ADD_X: begin
          st_d.res   = {x_hi[15:0], x_lo[15:0]};
          st_d.ge    = {{2{~x_hi[16]}}, {2{~x_lo[16]}}};
          st_d.ge_we = 1'b1;
        end
        OP_SELECT: begin
          // reads the flags held from earlier operations
          for (int k = 0; k < LANE_N; k++) begin
            st_d.res[8*k +: 8] = st_q.ge[k] ? a[8*k +: 8]
                                            : b[8*k +: 8];
          end
        end
        OP_DUAL_HADD: begin
          // dropping bit 0 of the wide sum is the arithmetic shift
          st_d.res = {h_hi[16:1], h_lo[16:1]};
        end
        OP_QUAD_HADD: begin
          for (int k = 0; k < LANE_N; k++) begin
            st_d.res[8*k +: 8] = bs[k][8:1];
          end
        end
        default: begin
          // unknown code: no write, nothing changes
          st_d.res_we = 1'b0;
        end
      endcase
    end
  end

  // ===========================================
  // registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '{res: RESULT_RST, res_we: 1'b0, ge: GE_RST, ge_we: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign result        = st_q.res;
  assign result_we     = st_q.res_we;
  assign lane_ge_flags = st_q.ge;
  assign lane_ge_we    = st_q.ge_we;

  // ===========================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // helper sums seen by the checks only
  logic [16:0] chk_lo;
  logic [16:0] chk_hi;
  assign chk_lo = {a[15], a[15:0]} + {b[15], b[15:0]};
  assign chk_hi = {a[31], a[31:16]} + {b[31], b[31:16]};

  sequence s_go(logic [3:0] c);
    op_valid && cond_pass && op_code == c;
  endsequence

  sequence s_keep_ge;
    !lane_ge_we && $stable(lane_ge_flags);
  endsequence

  property p_load_upper;
    s_go(OP_LOAD_UPPER) |=> result_we
      && result == {$past(upper_immediate), $past(dest_old[15:0])};
  endproperty
  a_load_upper: assert property (p_load_upper)
    else $error("upper load result wrong");

  property p_load_flags;
    s_go(OP_LOAD_UPPER) |=> s_keep_ge;
  endproperty
  a_load_flags: assert property (p_load_flags)
    else $error("upper load touched flags");

  property p_swap_word;
    s_go(OP_SWAP_WORD) |=> result[31:24] == $past(a[7:0])
      && result[7:0] == $past(a[31:24]);
  endproperty
  a_swap_word: assert property (p_swap_word)
    else $error("word swap wrong");

  property p_swap_half;
    s_go(OP_SWAP_HALF) |=> result[15:8] == $past(a[7:0])
      && result[23:16] == $past(a[31:24]);
  endproperty
  a_swap_half: assert property (p_swap_half)
    else $error("halfword swap wrong");

  property p_swap_sext;
    s_go(OP_SWAP_SEXT) |=> result[15:0] == {$past(a[7:0]), $past(a[15:8])}
      && result[31:16] == {16{$past(a[7])}};
  endproperty
  a_swap_sext: assert property (p_swap_sext)
    else $error("signed swap wrong");

  property p_mirror;
    s_go(OP_MIRROR) |=> result[0] == $past(a[31])
      && result[31] == $past(a[0]) && result[12] == $past(a[19]);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirror wrong");

  property p_no_flags;
    op_valid && cond_pass && (op_code inside {OP_SWAP_WORD, OP_SWAP_HALF,
      OP_SWAP_SEXT, OP_MIRROR, OP_SELECT, OP_DUAL_HADD, OP_QUAD_HADD})
      |=> s_keep_ge;
  endproperty
  a_no_flags: assert property (p_no_flags)
    else $error("flag changed by flagless op");

  property p_dual_add;
    s_go(OP_DUAL_ADD) |=> result_we
      && result == {$past(chk_hi[15:0]), $past(chk_lo[15:0])};
  endproperty
  a_dual_add: assert property (p_dual_add)
    else $error("dual add wrong");

  property p_dual_ge;
    s_go(OP_DUAL_ADD) |=> lane_ge_we
      && lane_ge_flags == {{2{!$past(chk_hi[16])}}, {2{!$past(chk_lo[16])}}};
  endproperty
  a_dual_ge: assert property (p_dual_ge)
    else $error("dual add flags wrong");

  property p_quad_add;
    s_go(OP_QUAD_ADD) |=> result[7:0] == $past(a[7:0] + b[7:0])
      && result[31:24] == $past(a[31:24] + b[31:24]);
  endproperty
  a_quad_add: assert property (p_quad_add)
    else $error("quad add wrong");

  property p_quad_ge;
    s_go(OP_QUAD_ADD) |=> lane_ge_we
      && {!lane_ge_flags[0], result[7:0]} == $past({a[7], a[7:0]} + {b[7], b[7:0]})
      && {!lane_ge_flags[3], result[31:24]} == $past({a[31], a[31:24]} + {b[31], b[31:24]});
  endproperty
  a_quad_ge: assert property (p_quad_ge)
    else $error("quad add flags wrong");

  property p_asx;
    s_go(OP_ADD_SUB_X) |=> result[15:0] == $past(a[15:0] - b[31:16])
      && result[31:16] == $past(a[31:16] + b[15:0]);
  endproperty
  a_asx: assert property (p_asx)
    else $error("add-sub exchange wrong");

  property p_asx_ge;
    s_go(OP_ADD_SUB_X) |=> lane_ge_we && lane_ge_flags[1] == lane_ge_flags[0]
      && {!lane_ge_flags[0], result[15:0]} == $past({a[15], a[15:0]} - {b[31], b[31:16]})
      && {!lane_ge_flags[3], result[31:16]} == $past({a[31], a[31:16]} + {b[15], b[15:0]});
  endproperty
  a_asx_ge: assert property (p_asx_ge)
    else $error("add-sub exchange flags wrong");

  property p_sax;
    s_go(OP_SUB_ADD_X) |=> result[15:0] == $past(a[15:0] + b[31:16])
      && result[31:16] == $past(a[31:16] - b[15:0]);
  endproperty
  a_sax: assert property (p_sax)
    else $error("sub-add exchange wrong");

  property p_sax_ge;
    s_go(OP_SUB_ADD_X) |=> lane_ge_we && lane_ge_flags[3] == lane_ge_flags[2]
      && {!lane_ge_flags[0], result[15:0]} == $past({a[15], a[15:0]} + {b[31], b[31:16]})
      && {!lane_ge_flags[2], result[31:16]} == $past({a[31], a[31:16]} - {b[15], b[15:0]});
  endproperty
  a_sax_ge: assert property (p_sax_ge)
    else $error("sub-add exchange flags wrong");

  property p_select;
    s_go(OP_SELECT) |=> result[7:0] == ($past(lane_ge_flags[0])
      ? $past(a[7:0]) : $past(b[7:0]));
  endproperty
  a_select: assert property (p_select)
    else $error("select wrong");

  property p_dual_hadd;
    s_go(OP_DUAL_HADD) |=> result == {$past(chk_hi[16:1]), $past(chk_lo[16:1])};
  endproperty
  a_dual_hadd: assert property (p_dual_hadd)
    else $error("dual halving add wrong");

  property p_quad_hadd;
    s_go(OP_QUAD_HADD) |=> result[7:0] == $past({a[7], a[7:0]} + {b[7], b[7:0]}) >> 1
      && result[31:24] == $past({a[31], a[31:24]} + {b[31], b[31:24]}) >> 1;
  endproperty
  a_quad_hadd: assert property (p_quad_hadd)
    else $error("quad halving add wrong");

  property p_cond_fail;
    op_valid && !cond_pass |=> (!result_we && $stable(result)) and s_keep_ge;
  endproperty
  a_cond_fail: assert property (p_cond_fail)
    else $error("failed condition still wrote");

endmodule : psa_alu

`default_nettype wire

// ### verif/psa_regfile_model.sv
// destination register model standing beside the alu slice
// assumes result_we is a one-cycle pulse on core_clk
`timescale 1ns/10ps
`default_nettype none

// ===========================================
// one destination register fed back as dest_old
module psa_regfile_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // write port from the datapath
  input  wire logic [31:0] result,
  input  wire logic        result_we,
  // read port back to the datapath
  output logic      [31:0] dest_old
);
  logic [31:0] reg_q;

  // write only on the pulse, so a refused op leaves the register alone
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_q <= 32'h0000_0000;
    end else if (result_we) begin
      reg_q <= result;
    end
  end

  // forward the write in flight, else a back-to-back upper load sees stale data
  assign dest_old = result_we ? result : reg_q;
endmodule : psa_regfile_model

`default_nettype wire

// ### verif/test_packed_simd_alu_slice.sv
// self-checking bench for the packed simd alu slice
// assumes psa_pkg and psa_alu compiled first; inputs move on falling edge
`timescale 1ns/10ps
`default_nettype none

module test_packed_simd_alu_slice;
  import psa_pkg::*;

  // ===========================================
  // signals
  logic        core_clk, reset, op_valid, cond_pass;
  logic [3:0]  op_code;
  logic [31:0] first_source, second_source, dest_old, result;
  logic [15:0] upper_immediate;
  logic        result_we, lane_ge_we;
  logic [3:0]  lane_ge_flags;
  logic [31:0] exp_r;
  logic [3:0]  exp_g;
  int          err_total, cmp_count;

  psa_alu dut (.core_clk(core_clk), .reset(reset), .op_valid(op_valid),
    .op_code(op_code), .cond_pass(cond_pass), .first_source(first_source),
    .second_source(second_source), .dest_old(dest_old),
    .upper_immediate(upper_immediate), .result(result), .result_we(result_we),
    .lane_ge_flags(lane_ge_flags), .lane_ge_we(lane_ge_we));

  psa_regfile_model regs (.core_clk(core_clk), .reset(reset), .result(result),
    .result_we(result_we), .dest_old(dest_old));

  // ===========================================
  // helpers
  function automatic logic [16:0] hs(input logic [15:0] x, y, input logic sub);
    return sub ? {x[15], x} - {y[15], y} : {x[15], x} + {y[15], y};
  endfunction : hs

  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // drive one request at a falling edge, judge it one cycle later;
  // op_valid stays up so calls run back to back
  task automatic run(input logic [3:0] op, input logic [31:0] a, b,
                     input logic [15:0] im, input logic cp);
    logic [31:0] r;
    logic [3:0]  g;
    logic [16:0] lo, hi;
    logic [8:0]  s;
    logic        gw, w;
    r = exp_r; g = exp_g; gw = 1'b0; w = cp && (op < 4'hC);
    lo = '0; hi = '0;
    if (w) begin
      case (op)
        4'h0: r = {im, exp_r[15:0]};
        4'h1: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
        4'h2: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
        4'h3: r = {{16{a[7]}}, a[7:0], a[15:8]};
        4'h4: for (int i = 0; i < 32; i++) r[i] = a[31-i];
        4'h5, 4'hA: begin
          lo = hs(a[15:0], b[15:0], 1'b0); hi = hs(a[31:16], b[31:16], 1'b0);
        end
        4'h7: begin
          lo = hs(a[15:0], b[31:16], 1'b1); hi = hs(a[31:16], b[15:0], 1'b0);
        end
        4'h8: begin
          lo = hs(a[15:0], b[31:16], 1'b0); hi = hs(a[31:16], b[15:0], 1'b1);
        end
        default: for (int k = 0; k < 4; k++) begin
          s = {a[8*k+7], a[8*k+:8]} + {b[8*k+7], b[8*k+:8]};
          if (op == 4'h6) begin
            r[8*k+:8] = s[7:0]; g[k] = ~s[8]; gw = 1'b1;
          end
          if (op == 4'hB) r[8*k+:8] = s[8:1];
          if (op == 4'h9) r[8*k+:8] = exp_g[k] ? a[8*k+:8] : b[8*k+:8];
        end
      endcase
      if (op inside {4'h5, 4'h7, 4'h8}) begin
        r = {hi[15:0], lo[15:0]}; g = {{2{~hi[16]}}, {2{~lo[16]}}}; gw = 1'b1;
      end
      if (op == 4'hA) r = {hi[16:1], lo[16:1]};
    end
    op_valid = 1'b1; op_code = op; first_source = a; second_source = b;
    upper_immediate = im; cond_pass = cp;
    @(negedge core_clk);
    chk({31'h0, result_we}, {31'h0, w});
    chk({31'h0, lane_ge_we}, {31'h0, gw});
    chk(result, r);
    chk({28'h0, lane_ge_flags}, {28'h0, g});
    exp_r = r; exp_g = g;
  endtask : run

  task automatic idle;
    op_valid = 1'b0;
    @(negedge core_clk);
  endtask : idle

  // ===========================================
  // scenarios
  task automatic sc_swap;
    for (logic [3:0] op = 4'h1; op <= 4'h4; op++) begin
      run(op, 32'h8122_33F4, 32'h0, 16'h0, 1'b1);
    end
    run(4'h0, 32'h0, 32'h0, 16'hF123, 1'b1);
    idle;
  endtask : sc_swap

  task automatic sc_add;
    run(4'h5, 32'h7FFF_8000, 32'h0001_FFFF, 16'h0, 1'b1);
    run(4'h6, 32'h7F80_0102, 32'h0180_FFFD, 16'h0, 1'b1);
    run(4'h9, 32'hAABB_CCDD, 32'h1122_3344, 16'h0, 1'b1);
    run(4'h7, 32'h8000_0001, 32'h0002_7FFF, 16'h0, 1'b1);
    run(4'h8, 32'h0001_8000, 32'hFFFF_0001, 16'h0, 1'b1);
    run(4'h9, 32'hAABB_CCDD, 32'h1122_3344, 16'h0, 1'b1);
    idle;
  endtask : sc_add

  task automatic sc_halve;
    run(4'hA, 32'h7FFF_8001, 32'h7FFF_8000, 16'h0, 1'b1);
    run(4'hB, 32'h7F80_FF01, 32'h7F80_FF00, 16'h0, 1'b1);
    run(4'h0, 32'h0, 32'h0, 16'h1234, 1'b1);
    idle;
  endtask : sc_halve

  task automatic sc_refuse;
    run(4'h6, 32'h0102_0304, 32'h0102_0304, 16'h0, 1'b1);
    run(4'h5, 32'h8000_8000, 32'h8000_8000, 16'h0, 1'b0);
    run(4'h0, 32'h0, 32'h0, 16'h5A5A, 1'b0);
    run(4'hC, 32'h8000_8000, 32'h8000_8000, 16'h0, 1'b1);
    idle;
  endtask : sc_refuse

  // ===========================================
  // clock, reset, sequence and watchdog
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    err_total = 0; cmp_count = 0; exp_r = '0; exp_g = '0;
    reset = 1'b1; op_valid = 1'b0; op_code = 4'h0; cond_pass = 1'b0;
    first_source = '0; second_source = '0; upper_immediate = '0;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    chk(result, 32'h0);
    chk({28'h0, lane_ge_flags}, 32'h0);
    sc_swap;
    sc_add;
    sc_halve;
    sc_refuse;
    tally_and_finish;
  end

  // the whole run needs well under a hundred cycles
  initial begin
    repeat (2000) @(posedge core_clk);
    err_total++;
    tally_and_finish;
  end
endmodule : test_packed_simd_alu_slice

`default_nettype wire
